/* hw/dsv_pkg.sv */
// Purpose: shared constants and carrier types for the dsp supervision block
// Assumes: avalon-mm slave, 32-bit data, word-indexed register offsets
// Notes:   byte address = 4 * register index
package dsv_pkg;
    // register indices
    localparam logic [15:0] IDX_PANIC_LO   = 16'hf433;
    localparam logic [15:0] IDX_PANIC_HI   = 16'hf434;
    localparam logic [15:0] IDX_WD_START   = 16'hf443;
    localparam logic [15:0] IDX_WD_DIV     = 16'hf444;
    localparam logic [15:0] IDX_FG_EN      = 16'hf450;
    localparam logic [15:0] IDX_FG_LEN     = 16'hf451;
    localparam logic [15:0] IDX_EP_HIGH    = 16'hf460;
    localparam logic [15:0] IDX_EP_LOW     = 16'hf461;
    localparam logic [15:0] IDX_EP_CLR     = 16'hf462;
    localparam logic [15:0] IDX_PEAK_HIGH  = 16'hf465;
    localparam logic [15:0] IDX_PEAK_LOW   = 16'hf466;
    localparam logic [15:0] IDX_STATUS     = 16'hf470;
    localparam int          ADDR_W         = 18;
    // field layout and resets
    localparam int          WD_START_W     = 13;
    localparam int          WD_CODE_W      = 4;
    localparam logic [3:0]  WD_CODE_MAX    = 4'hb;
    localparam int          WD_BASE_LOG2   = 6;
    localparam int          WD_PRE_W       = 17;
    localparam int          WDOG_ERR_BIT   = 12;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam int          EP_W           = 24;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    // avalon request and answer carriers
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } dsv_req_s;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } dsv_rsp_s;

    typedef enum logic [1:0] {BUS_IDLE, BUS_DONE} dsv_bus_e;
endpackage

/* hw/dsv_supervisor.sv */
// Purpose: dsp core supervision: panic capture, watchdog, frame group irq, exec pointer
// Assumes: core strobes come from logic on SYS_CLK; avalon-mm with waitrequest
// Notes:   every access answers one cycle after it is presented
//
// Function
// - on software panic capture low half of executing instruction word
// - on software panic capture high half of executing instruction word
// - watchdog loads start value and counts down one per prescaled step
// - watchdog reloads whenever the program restarts for a new frame
// - watchdog reaching zero raises an error flag to the panic manager
// - watchdog start value is 13-bit field, reset zero, top bits reserved
// - 4-bit step code: 64 cycles doubling per code up to 32768 at code 9, codes 10 and 11 give 1 and 2 cycles
// - timeout equals prescale factor times configured start count
// - bit 0 enable gates frame group interrupts, reset zero
// - frame group counter advances on each frame-start pulse while bit 0 enable is set
// - at programmed length issue interrupt and restart the counter
// - exec pointer readable as upper byte and lower half registers
// - clear bit set clears exec pointer and freezes it
// - set then clear of clear bit resets stored peak value
// - peak tracks highest exec pointer since core start
// - watchdog expiry sets panic source bit 12, a WDOG_CODE_SET pulse on every expiry
`timescale 1ns/10ps
module dsv_supervisor (
    input  wire logic                     SYS_CLK,        // core clock, 200 MHz
    input  wire logic                     NRST,           // async reset, active low
    input  wire dsv_pkg::dsv_req_s        AVS_REQ,        // avalon request
    output dsv_pkg::dsv_rsp_s             AVS_RSP,        // avalon answer
    input  wire logic                     SW_PANIC,       // software panic pulse
    input  wire logic [31:0]              INSTR_WORD,     // instruction in execute
    input  wire logic                     PROG_RESTART,   // jump to program start
    input  wire logic                     FRAME_START,    // audio frame-start pulse
    input  wire logic [dsv_pkg::EP_W-1:0] CORE_PC,        // live program counter
    output logic                          WDOG_ERR,       // watchdog error flag, sticky
    output logic                          WDOG_CODE_SET,  // pulse: set panic code bit
    output logic                          FRAME_GROUP_IRQ,// one-cycle block interrupt
    output logic                          EP_FROZEN       // exec pointer held clear
);
    import dsv_pkg::*;

    // whole module state
    typedef struct packed {
        dsv_bus_e                bus;
        logic [31:0]             rdata;
        logic [15:0]             panic_lo;
        logic [15:0]             panic_hi;
        logic [WD_START_W-1:0]   wd_start;
        logic [WD_CODE_W-1:0]    wd_code;
        logic [WD_START_W-1:0]   wd_cnt;
        logic [WD_PRE_W-1:0]     wd_pre;
        logic                    wd_err;
        logic                    wd_code_set;
        logic                    fg_en;
        logic [15:0]             fg_len;
        logic [15:0]             fg_cnt;
        logic                    fg_irq;
        logic                    ep_clr;
        logic [EP_W-1:0]         ep;
        logic [EP_W-1:0]         peak;
    } dsv_state_s;

    dsv_state_s st_r;
    dsv_state_s st_nxt;

    logic [15:0]         idx;
    logic                wr_go;
    logic                rd_go;
    logic [WD_PRE_W-1:0] pre_last;
    logic                step;

    // word index from byte address
    assign idx   = AVS_REQ.address[ADDR_W-1:2];
    // a write commits only at the edge that sees waitrequest low
    assign wr_go = AVS_REQ.write && (st_r.bus == BUS_DONE);
    assign rd_go = AVS_REQ.read && (st_r.bus == BUS_IDLE);

    // step period: 64 << code cycles up to code 9, 4-bit shift sum wraps so codes 10 and 11 give 1 and 2, reserved codes clamp to 11
    always_comb begin
        logic [3:0] code;
        code = (st_r.wd_code > WD_CODE_MAX) ? WD_CODE_MAX : st_r.wd_code;
        pre_last = WD_PRE_W'((18'd1 << (code + 4'(WD_BASE_LOG2))) - 18'd1);
    end
    assign step = (st_r.wd_pre == pre_last);

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.wd_code_set = 1'b0;
        st_nxt.fg_irq      = 1'b0;

        // bus: answer one cycle after the request is seen
        case (st_r.bus)
            BUS_IDLE: begin
                if (AVS_REQ.read || AVS_REQ.write) begin
                    st_nxt.bus = BUS_DONE;
                end
            end
            BUS_DONE: begin
                st_nxt.bus = BUS_IDLE;
            end
            default: begin
                st_nxt.bus = BUS_IDLE;
            end
        endcase

        // register reads
        if (rd_go) begin
            case (idx)
                IDX_PANIC_LO:  st_nxt.rdata = {16'h0000, st_r.panic_lo};
                IDX_PANIC_HI:  st_nxt.rdata = {16'h0000, st_r.panic_hi};
                IDX_WD_START:  st_nxt.rdata = {19'h00000, st_r.wd_start};
                IDX_WD_DIV:    st_nxt.rdata = {28'h0000000, st_r.wd_code};
                IDX_FG_EN:     st_nxt.rdata = {31'h00000000, st_r.fg_en};
                IDX_FG_LEN:    st_nxt.rdata = {16'h0000, st_r.fg_len};
                IDX_EP_HIGH:   st_nxt.rdata = {24'h000000, st_r.ep[23:16]};
                IDX_EP_LOW:    st_nxt.rdata = {16'h0000, st_r.ep[15:0]};
                IDX_EP_CLR:    st_nxt.rdata = {31'h00000000, st_r.ep_clr};
                IDX_PEAK_HIGH: st_nxt.rdata = {24'h000000, st_r.peak[23:16]};
                IDX_PEAK_LOW:  st_nxt.rdata = {16'h0000, st_r.peak[15:0]};
                IDX_STATUS:    st_nxt.rdata = {31'h00000000, st_r.wd_err};
                default:       st_nxt.rdata = UNMAPPED_DATA;
            endcase
        end

        // register writes, low byte lanes
        if (wr_go) begin
            case (idx)
                IDX_PANIC_LO: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.panic_lo[7:0]  = AVS_REQ.writedata[7:0];
                    if (AVS_REQ.byteenable[1]) st_nxt.panic_lo[15:8] = AVS_REQ.writedata[15:8];
                end
                IDX_PANIC_HI: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.panic_hi[7:0]  = AVS_REQ.writedata[7:0];
                    if (AVS_REQ.byteenable[1]) st_nxt.panic_hi[15:8] = AVS_REQ.writedata[15:8];
                end
                IDX_WD_START: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.wd_start[7:0]  = AVS_REQ.writedata[7:0];
                    if (AVS_REQ.byteenable[1]) st_nxt.wd_start[12:8] = AVS_REQ.writedata[12:8];
                end
                IDX_WD_DIV: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.wd_code = AVS_REQ.writedata[3:0];
                end
                IDX_FG_EN: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.fg_en = AVS_REQ.writedata[0];
                end
                IDX_FG_LEN: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.fg_len[7:0]  = AVS_REQ.writedata[7:0];
                    if (AVS_REQ.byteenable[1]) st_nxt.fg_len[15:8] = AVS_REQ.writedata[15:8];
                end
                IDX_EP_CLR: begin
                    if (AVS_REQ.byteenable[0]) st_nxt.ep_clr = AVS_REQ.writedata[0];
                end
                IDX_STATUS: begin
                    // write one to bit 0 acknowledges the watchdog flag
                    if (AVS_REQ.byteenable[0] && AVS_REQ.writedata[0]) st_nxt.wd_err = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // panic capture overrides a same-cycle software write
        if (SW_PANIC) begin
            st_nxt.panic_lo = INSTR_WORD[15:0];
            st_nxt.panic_hi = INSTR_WORD[31:16];
        end

        // watchdog: prescaler then down counter
        if (PROG_RESTART) begin
            st_nxt.wd_cnt = st_r.wd_start;
            st_nxt.wd_pre = '0;
        end else begin
            st_nxt.wd_pre = step ? '0 : st_r.wd_pre + 1'b1;
            if (step && st_r.wd_cnt != '0) begin
                st_nxt.wd_cnt = st_r.wd_cnt - 1'b1;
                if (st_r.wd_cnt == WD_START_W'(1)) begin
                    st_nxt.wd_err      = 1'b1;
                    st_nxt.wd_code_set = 1'b1;
                end
            end
        end

        // frame group counter
        if (FRAME_START && st_r.fg_en) begin
            if (st_r.fg_cnt + 16'h0001 >= st_r.fg_len) begin
                st_nxt.fg_cnt = '0;
                st_nxt.fg_irq = 1'b1;
            end else begin
                st_nxt.fg_cnt = st_r.fg_cnt + 16'h0001;
            end
        end

        // exec pointer and its peak
        if (st_r.ep_clr) begin
            st_nxt.ep = '0;
        end else begin
            st_nxt.ep = CORE_PC;
            if (CORE_PC > st_r.peak) st_nxt.peak = CORE_PC;
        end
        if (st_r.ep_clr && !st_nxt.ep_clr) begin
            st_nxt.peak = '0;
        end
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '{bus: BUS_IDLE, rdata: 32'h0000_0000, panic_lo: REG_RESET,
                      panic_hi: REG_RESET, wd_start: '0, wd_code: '0, wd_cnt: '0,
                      wd_pre: '0, wd_err: 1'b0, wd_code_set: 1'b0, fg_en: 1'b0,
                      fg_len: REG_RESET, fg_cnt: '0, fg_irq: 1'b0, ep_clr: 1'b0,
                      ep: '0, peak: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state
    assign AVS_RSP.waitrequest = (st_r.bus != BUS_DONE);
    assign AVS_RSP.readdata    = st_r.rdata;
    assign WDOG_ERR            = st_r.wd_err;
    assign WDOG_CODE_SET       = st_r.wd_code_set;
    assign FRAME_GROUP_IRQ     = st_r.fg_irq;
    assign EP_FROZEN           = st_r.ep_clr;
endmodule // dsv_supervisor

/* testbench/dsv_supervisor_properties.sv */
// Purpose: port checks for the supervision block
// Assumes: one clock domain, NRST async active low
// Notes:   attached to dsv_supervisor by bind
`timescale 1ns/10ps
module dsv_sup_checker (
    input wire logic                     SYS_CLK,         // clock
    input wire logic                     NRST,            // reset
    input wire dsv_pkg::dsv_req_s        AVS_REQ,         // bus request
    input wire dsv_pkg::dsv_rsp_s        AVS_RSP,         // bus answer
    input wire logic                     SW_PANIC,        // panic
    input wire logic [31:0]              INSTR_WORD,      // instruction
    input wire logic                     PROG_RESTART,    // restart
    input wire logic                     FRAME_START,     // frame start
    input wire logic [dsv_pkg::EP_W-1:0] CORE_PC,         // program counter
    input wire logic                     WDOG_ERR,        // watchdog error
    input wire logic                     WDOG_CODE_SET,   // code pulse
    input wire logic                     FRAME_GROUP_IRQ, // block irq
    input wire logic                     EP_FROZEN        // pointer held
);
    import dsv_pkg::*;
    logic [15:0] idx;
    logic        wr_st;
    logic        wr_clr;
    // register index decode
    assign idx    = AVS_REQ.address[17:2];
    assign wr_st  = AVS_REQ.write && idx == IDX_STATUS && AVS_REQ.writedata[0];
    assign wr_clr = AVS_REQ.write && idx == IDX_EP_CLR;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // bus handshake steps
    sequence s_taken; (AVS_REQ.read || AVS_REQ.write) && AVS_RSP.waitrequest; endsequence
    sequence s_ack; !AVS_RSP.waitrequest ##1 AVS_RSP.waitrequest; endsequence
    property p_ack; s_taken |=> s_ack; endproperty
    property p_ack_cause; $fell(AVS_RSP.waitrequest) |-> $past(AVS_REQ.read || AVS_REQ.write); endproperty
    property p_irq_cause; FRAME_GROUP_IRQ |-> $past(FRAME_START); endproperty
    property p_err_sticky; $fell(WDOG_ERR) |-> $past(wr_st); endproperty
    property p_err_code; $rose(WDOG_ERR) |-> WDOG_CODE_SET; endproperty
    property p_code_pulse; WDOG_CODE_SET |-> WDOG_ERR ##1 !WDOG_CODE_SET; endproperty
    property p_frozen_cause; $changed(EP_FROZEN) |-> $past(wr_clr) || $past(wr_clr, 2); endproperty
    property p_restart_quiet; PROG_RESTART |=> !WDOG_CODE_SET [*8]; endproperty
    a_ack: assert property (p_ack) else $error("bus answer late or long");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without frame");
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");
    a_err_code: assert property (p_err_code) else $error("no code pulse");
    a_code_pulse: assert property (p_code_pulse) else $error("bad code pulse");
    a_frozen_cause: assert property (p_frozen_cause) else $error("freeze moved");
    a_restart_quiet: assert property (p_restart_quiet) else $error("expiry after reload");
endmodule // dsv_sup_checker
bind dsv_supervisor dsv_sup_checker u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .AVS_REQ(AVS_REQ),
    .AVS_RSP(AVS_RSP), .SW_PANIC(SW_PANIC), .INSTR_WORD(INSTR_WORD), .PROG_RESTART(PROG_RESTART),
    .FRAME_START(FRAME_START), .CORE_PC(CORE_PC), .WDOG_ERR(WDOG_ERR),
    .WDOG_CODE_SET(WDOG_CODE_SET), .FRAME_GROUP_IRQ(FRAME_GROUP_IRQ), .EP_FROZEN(EP_FROZEN));

/* testbench/tb_dsv_supervisor.sv */
// Purpose: self-checking bench for the supervision block
// Assumes: bus answers one cycle after a request
// Notes:   watchdog limits check 4 cycles before and 4 after the nominal timeout; restart clears the prescaler
`timescale 1ns/10ps
module tb_dsv_supervisor;
    import dsv_pkg::*;
    logic            clk, nrst, panic, restart_s, frame, err, code, irq, frz;
    logic [31:0]     instr;
    logic [EP_W-1:0] pc;
    dsv_req_s        req;
    dsv_rsp_s        rsp;
    logic [15:0]     rd;
    int              bad_count, cmp_count, cycles, irqs, codes;
    logic [15:0]     tab [9] = '{IDX_PANIC_LO, IDX_PANIC_HI, IDX_WD_START, IDX_WD_DIV,
                                 IDX_FG_EN, IDX_FG_LEN, IDX_EP_HIGH, IDX_EP_LOW, IDX_EP_CLR};
    dsv_supervisor dut (.SYS_CLK(clk), .NRST(nrst), .AVS_REQ(req), .AVS_RSP(rsp),
        .SW_PANIC(panic), .INSTR_WORD(instr), .PROG_RESTART(restart_s), .FRAME_START(frame),
        .CORE_PC(pc), .WDOG_ERR(err), .WDOG_CODE_SET(code), .FRAME_GROUP_IRQ(irq), .EP_FROZEN(frz));
    // clock and run limit
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (code === 1'b1) codes++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {16'h0, wd},
                 byteenable: 4'hf};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 20);
        if (n == 20) bad_count++;
        rd = rsp.readdata[15:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0);
        chk({16'h0, rd}, {16'h0, exp});
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk) frame <= 1'b1;
            @(posedge clk) frame <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic restart();
        @(posedge clk) restart_s <= 1'b1;
        @(posedge clk) restart_s <= 1'b0;
    endtask
    // main sequence
    initial begin
        {nrst, panic, restart_s, frame, instr, pc, req} = '0;
        {bad_count, cmp_count, cycles, irqs, codes} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        foreach (tab[i]) rchk(tab[i], REG_RESET);
        rchk(16'hf4ff, 16'h0);
        bus(1'b1, IDX_WD_START, 16'h1abc);
        rchk(IDX_WD_START, 16'h1abc);
        bus(1'b1, IDX_EP_HIGH, 16'h00ff);
        rchk(IDX_EP_HIGH, 16'h0);
        instr <= 32'hcafe1234;
        panic <= 1'b1;
        @(posedge clk) panic <= 1'b0;
        rchk(IDX_PANIC_LO, 16'h1234);
        rchk(IDX_PANIC_HI, 16'hcafe);
        pc <= 24'hab5678;
        rchk(IDX_EP_HIGH, 16'h00ab);
        rchk(IDX_EP_LOW, 16'h5678);
        rchk(IDX_PEAK_HIGH, 16'h00ab);
        bus(1'b1, IDX_EP_CLR, 16'h1);
        pc <= 24'h10;
        rchk(IDX_EP_LOW, 16'h0);
        chk({31'h0, frz}, 32'h1);
        bus(1'b1, IDX_EP_CLR, 16'h0);
        rchk(IDX_PEAK_LOW, 16'h0010);
        rchk(IDX_PEAK_HIGH, 16'h0);
        frames(4);
        chk(irqs, 0);
        bus(1'b1, IDX_FG_LEN, 16'h3);
        bus(1'b1, IDX_FG_EN, 16'h1);
        frames(6);
        chk(irqs, 2);
        bus(1'b1, IDX_WD_START, 16'h2);
        repeat (6) begin
            restart();
            repeat (50) @(posedge clk);
        end
        chk({31'h0, err}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, IDX_WD_DIV, 16'(c));
            bus(1'b1, IDX_STATUS, 16'h1);
            restart();
            repeat ((128 << c) - 4) @(posedge clk);
            chk({31'h0, err}, 32'h0);
            repeat (8) @(posedge clk);
            chk({31'h0, err}, 32'h1);
        end
        chk(codes, 4);
        print_verdict();
    end
endmodule // tb_dsv_supervisor
